// [clock_power_mode_control.sv]
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Function
// - Deep sleep stops core and system clocks
// - Deep sleep blocks RTC resource access
// - Only reset or RTC wake exits
// - RTC wake from deep goes active
// - Reset in deep goes full-on
// - Voltage code steps 50 mV
// - Hibernate exits on RTC wake into boot, or on reset straight to full-on
// - Multiplier 1x to 63x
// - Multiplier resets to 10x
// - Divider writes apply while running
// - System divider 1 to 15
// - System divider change without relock
// - Core divider 1, 2, 4, 8
// - Active mode runs clocks at input rate
// - Power-up enters full-on
// - Sleep wake checks bypass bit
module clock_power_mode_control
   import cpmc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rtcWake,
   input wire logic extWake,
   input wire logic rtcAccessReq,
   output logic rtcAccessGrant,
   output logic coreClkEn,
   output logic sysClkEn,
   output logic corePowerOn,
   output logic bootStart,
   output logic [11:0] coreVoltageMv
);
   logic [5:0] msel_q, msel_d;
   logic bypass_q, bypass_d;
   logic pllOff_q, pllOff_d;
   logic [3:0] ssel_q, ssel_d;
   logic [1:0] csel_q, csel_d;
   logic [3:0] vlev_q, vlev_d;
   logic hib_q, hib_d;
   logic [7:0] boot_q, boot_d;
   logic [31:0] rdata_q, rdata_d;
   logic slverr_q, slverr_d;
   logic coreEn_q, coreEn_d;
   logic sysEn_q, sysEn_d;
   logic grant_q, grant_d;
   logic bootPulse_q, bootPulse_d;
   logic [11:0] mv_q, mv_d;
   cpmc_mode_t mode_q, mode_d;
   logic access;
   logic setup;
   logic wr;
   logic rd;
   logic mapped;
   logic runMode;
   logic pllRun;
   logic vcoEn;
   logic coreTick;
   logic sysTick;
   logic srcEn;
   logic [7:0] coreRatio;

   // Read data and error are registered in setup so that they
   // already stand at the access edge with no wait state
   // Trade: a status read shows the mode of the setup cycle
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign rd = setup && !pwrite;
   assign pready = 1'b1;

   always_comb begin
      unique case (paddr)
         CPMC_PLL_CONTROL_REG_OFF, CPMC_DIV_OFF, CPMC_VR_OFF,
         CPMC_CMD_OFF, CPMC_STAT_OFF: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Deep sleep and hibernate share every blocking decision
   function automatic logic cpmc_halted(input cpmc_mode_t m);
      cpmc_halted = (m == CPMC_DEEP) || (m == CPMC_HIB);
   endfunction : cpmc_halted

   // Only the run modes may take a sleep or deep sleep command
   assign runMode = (mode_q == CPMC_FULL_ON) || (mode_q == CPMC_ACTIVE);
   // PLL runs unless off or in deep sleep / hibernate
   assign pllRun = !pllOff_q && !cpmc_halted(mode_q);
   // Active mode uses ref_clk directly, so every cycle is a tick
   assign srcEn = (mode_q == CPMC_ACTIVE) ? 1'b1 : vcoEn;

   cpmc_pll u_pll (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .enable(pllRun),
      .mult(msel_q),
      .vcoEn(vcoEn)
   );

   // Core divider 1,2,4,8 from two-bit code
   assign coreRatio = 8'h01 << csel_q;

   cpmc_clk_div u_core_div (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .srcEn(srcEn),
      .ratio((mode_q == CPMC_ACTIVE) ? 8'h01 : coreRatio),
      .tickEn(coreTick)
   );

   cpmc_clk_div u_sys_div (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .srcEn(srcEn),
      // No relock wait: new ratio applies to the running count
      .ratio((mode_q == CPMC_ACTIVE) ? 8'h01 : {4'h0, ssel_q}),
      .tickEn(sysTick)
   );

   always_comb begin
      msel_d = msel_q;
      bypass_d = bypass_q;
      pllOff_d = pllOff_q;
      ssel_d = ssel_q;
      csel_d = csel_q;
      vlev_d = vlev_q;
      hib_d = hib_q;
      mode_d = mode_q;
      boot_d = boot_q;
      bootPulse_d = 1'b0;
      slverr_d = 1'b0;
      rdata_d = rdata_q;
      // Error flag stands for the access cycle only
      if (setup) begin
         slverr_d = !mapped;
      end
      if (wr && mapped) begin
         unique case (paddr)
            CPMC_PLL_CONTROL_REG_OFF: begin
               // Zero multiplier ignored, range 1..63
               if (pwdata[CPMC_MSEL_LSB +: CPMC_MSEL_W] != 6'h00) begin
                  msel_d = pwdata[CPMC_MSEL_LSB +: CPMC_MSEL_W];
               end
               bypass_d = pwdata[CPMC_BYPASS_BIT];
               pllOff_d = pwdata[CPMC_PLLOFF_BIT];
               // Entering or leaving bypass from run modes
               if (mode_q == CPMC_FULL_ON && pwdata[CPMC_BYPASS_BIT]) begin
                  mode_d = CPMC_ACTIVE;
               end else if (mode_q == CPMC_ACTIVE
                            && !pwdata[CPMC_BYPASS_BIT]
                            && !pwdata[CPMC_PLLOFF_BIT]) begin
                  mode_d = CPMC_FULL_ON;
               end
            end
            CPMC_DIV_OFF: begin
               // Applied at once, processor keeps running
               if (pwdata[CPMC_SSEL_LSB +: 4] != 4'h0) begin
                  ssel_d = pwdata[CPMC_SSEL_LSB +: 4];
               end
               csel_d = pwdata[CPMC_CSEL_LSB +: 2];
            end
            CPMC_VR_OFF: begin
               vlev_d = pwdata[CPMC_VLEV_LSB +: CPMC_VLEV_W];
               hib_d = pwdata[CPMC_HIB_BIT];
               // Deep sleep is left only by RTC wake or reset
               if (pwdata[CPMC_HIB_BIT] && mode_q != CPMC_DEEP) begin
                  mode_d = CPMC_HIB;
               end
            end
            CPMC_CMD_OFF: begin
               // A command in a stopped mode must not end it
               if (runMode) begin
                  if (pwdata[CPMC_CMD_DEEP_BIT]) begin
                     mode_d = CPMC_DEEP;
                  end else if (pwdata[CPMC_CMD_SLEEP_BIT]
                               && !(pllOff_q && !bypass_q)) begin
                     // Sleep needs a running PLL or bypass
                     mode_d = CPMC_SLEEP;
                  end
               end
            end
            default: begin
            end
         endcase
      end
      // Wake events win over any register write of the same cycle
      unique case (mode_q)
         CPMC_SLEEP: begin
            if (rtcWake || extWake) begin
               mode_d = bypass_q ? CPMC_ACTIVE : CPMC_FULL_ON;
            end
         end
         CPMC_DEEP: begin
            // Only RTC wake leaves; ext wake ignored here
            if (rtcWake) begin
               mode_d = CPMC_ACTIVE;
               bypass_d = 1'b1;
            end
         end
         CPMC_HIB: begin
            if (rtcWake) begin
               mode_d = CPMC_BOOT;
               hib_d = 1'b0;
               boot_d = CPMC_BOOT_CYC;
               bootPulse_d = 1'b1;
            end
         end
         CPMC_BOOT: begin
            if (boot_q == 8'h00) begin
               mode_d = CPMC_FULL_ON;
            end else begin
               boot_d = boot_q - 8'h01;
            end
         end
         default: begin
         end
      endcase
      // Read mux loaded in the setup cycle
      if (rd) begin
         unique case (paddr)
            CPMC_PLL_CONTROL_REG_OFF: rdata_d = {22'h0, pllOff_q, bypass_q,
                                         2'h0, msel_q};
            CPMC_DIV_OFF: rdata_d = {26'h0, csel_q, ssel_q};
            CPMC_VR_OFF: rdata_d = {23'h0, hib_q, 4'h0, vlev_q};
            CPMC_STAT_OFF: rdata_d = {29'h0, cpmc_mode_code(mode_q)};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      // Gated clocks stop in deep sleep and hibernate
      coreEn_d = coreTick && (mode_q == CPMC_FULL_ON
                              || mode_q == CPMC_ACTIVE);
      sysEn_d = sysTick && (mode_q == CPMC_FULL_ON
                            || mode_q == CPMC_ACTIVE
                            || mode_q == CPMC_SLEEP);
      // RTC cannot reach resources in deep sleep or hibernate
      grant_d = rtcAccessReq && !cpmc_halted(mode_q);
      // Code n gives base plus n times step
      mv_d = 12'(CPMC_VBASE_MV + CPMC_VSTEP_MV * int'(vlev_q));
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         // Reset from any mode, deep sleep included, lands in full-on
         mode_q <= CPMC_FULL_ON;
         msel_q <= CPMC_MSEL_RST;
         bypass_q <= 1'b0;
         pllOff_q <= 1'b0;
         ssel_q <= CPMC_SSEL_RST;
         csel_q <= CPMC_CSEL_RST;
         vlev_q <= CPMC_VLEV_RST;
         hib_q <= 1'b0;
         boot_q <= 8'h00;
         bootPulse_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
         coreEn_q <= 1'b0;
         sysEn_q <= 1'b0;
         grant_q <= 1'b0;
         mv_q <= 12'h000;
      end else begin
         mode_q <= mode_d;
         msel_q <= msel_d;
         bypass_q <= bypass_d;
         pllOff_q <= pllOff_d;
         ssel_q <= ssel_d;
         csel_q <= csel_d;
         vlev_q <= vlev_d;
         hib_q <= hib_d;
         boot_q <= boot_d;
         bootPulse_q <= bootPulse_d;
         rdata_q <= rdata_d;
         slverr_q <= slverr_d;
         coreEn_q <= coreEn_d;
         sysEn_q <= sysEn_d;
         grant_q <= grant_d;
         mv_q <= mv_d;
      end
   end

   // Data and error flops, loaded in the setup cycle
   assign prdata = rdata_q;
   assign pslverr = slverr_q;
   assign coreClkEn = coreEn_q;
   assign sysClkEn = sysEn_q;
   assign rtcAccessGrant = grant_q;
   assign corePowerOn = mode_q != CPMC_HIB;
   assign bootStart = bootPulse_q;
   assign coreVoltageMv = mv_q;
endmodule : clock_power_mode_control

// [cpmc_asserts.sv]
`timescale 1ns/1ps
module cpmc_asserts (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pslverr,
   input wire logic rtcAccessReq,
   input wire logic rtcAccessGrant,
   input wire logic coreClkEn,
   input wire logic sysClkEn,
   input wire logic corePowerOn,
   input wire logic bootStart,
   input wire logic [11:0] coreVoltageMv
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   chk_grant_cause: assert property (
      rtcAccessGrant |-> $past(rtcAccessReq)) else $error("stray grant");
   chk_grant_drop: assert property (
      $fell(rtcAccessReq) |=> !rtcAccessGrant) else $error("grant held");
   // First powered-off cycle may still carry a late grant or tick
   chk_hib_grant: assert property (
      !corePowerOn && $past(!corePowerOn) |-> !rtcAccessGrant)
      else $error("grant while off");
   chk_hib_clocks: assert property (
      !corePowerOn && $past(!corePowerOn) |-> !coreClkEn && !sysClkEn)
      else $error("clock while off");
   chk_volt_grid: assert property (
      $past(resetn) |-> coreVoltageMv >= 12'h352
      && coreVoltageMv <= 12'h640 && coreVoltageMv % 12'h032 == 12'h000)
      else $error("voltage off grid");
   chk_boot_cause: assert property (
      bootStart |-> corePowerOn && !$past(corePowerOn))
      else $error("boot without wake");
   chk_boot_pulse: assert property (
      bootStart |=> !bootStart) else $error("boot pulse long");
   // Refusal answers only an access
   chk_err_cause: assert property (
      pslverr |-> psel && penable) else $error("stray error");
endmodule : cpmc_asserts

// [cpmc_clk_div.sv]
`timescale 1ns/1ps
// Enable pulse once every ratio cycles of the source enable
module cpmc_clk_div
   import cpmc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic srcEn,
   input wire logic [7:0] ratio,
   output logic tickEn
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   always_comb begin
      cnt_d = cnt_q;
      if (srcEn) begin
         // Ratio change applies to the running count at once, no glitch pulse
         if (cnt_q + 8'h01 >= ratio) begin
            cnt_d = 8'h00;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign tickEn = srcEn && (cnt_q + 8'h01 >= ratio);
endmodule : cpmc_clk_div

// [cpmc_pkg.sv]
package cpmc_pkg;
   // Register byte offsets
   localparam logic [11:0] CPMC_PLL_CONTROL_REG_OFF = 12'h000;
   localparam logic [11:0] CPMC_DIV_OFF = 12'h004;
   localparam logic [11:0] CPMC_VR_OFF = 12'h008;
   localparam logic [11:0] CPMC_CMD_OFF = 12'h00C;
   localparam logic [11:0] CPMC_STAT_OFF = 12'h010;
   // pll_control_reg fields
   localparam int CPMC_MSEL_LSB = 0;
   localparam int CPMC_MSEL_W = 6;
   localparam int CPMC_BYPASS_BIT = 8;
   localparam int CPMC_PLLOFF_BIT = 9;
   // Divider register fields
   localparam int CPMC_SSEL_LSB = 0;
   localparam int CPMC_CSEL_LSB = 4;
   // regulator_control_reg fields
   localparam int CPMC_VLEV_LSB = 0;
   localparam int CPMC_VLEV_W = 4;
   localparam int CPMC_HIB_BIT = 8;
   // Command register bits
   localparam int CPMC_CMD_SLEEP_BIT = 0;
   localparam int CPMC_CMD_DEEP_BIT = 1;
   // Reset values
   localparam logic [5:0] CPMC_MSEL_RST = 6'h0A;
   localparam logic [3:0] CPMC_SSEL_RST = 4'h5;
   localparam logic [1:0] CPMC_CSEL_RST = 2'h0;
   localparam logic [3:0] CPMC_VLEV_RST = 4'h7;
   // Core voltage: base plus step per code
   localparam int CPMC_VSTEP_MV = 50;
   localparam int CPMC_VBASE_MV = 850;
   // Boot countdown load; boot mode lasts this many cycles plus one
   localparam logic [7:0] CPMC_BOOT_CYC = 8'h10;
   typedef enum {
      CPMC_FULL_ON, CPMC_ACTIVE, CPMC_SLEEP, CPMC_DEEP, CPMC_HIB, CPMC_BOOT
   } cpmc_mode_t;
   function automatic logic [2:0] cpmc_mode_code(input cpmc_mode_t m);
      unique case (m)
         CPMC_FULL_ON: cpmc_mode_code = 3'h0;
         CPMC_ACTIVE: cpmc_mode_code = 3'h1;
         CPMC_SLEEP: cpmc_mode_code = 3'h2;
         CPMC_DEEP: cpmc_mode_code = 3'h3;
         CPMC_HIB: cpmc_mode_code = 3'h4;
         CPMC_BOOT: cpmc_mode_code = 3'h5;
      endcase
   endfunction : cpmc_mode_code
endpackage : cpmc_pkg

// [cpmc_pll.sv]
`timescale 1ns/1ps
// Behavioural VCO: a tick rate of mult/64 of ref_clk stands in for multiply
module cpmc_pll
   import cpmc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic enable,
   input wire logic [5:0] mult,
   output logic vcoEn
);
   logic [6:0] acc_q;
   logic [6:0] acc_d;
   logic [6:0] sum;
   always_comb begin
      sum = acc_q + {1'b0, mult};
      acc_d = enable ? {1'b0, sum[5:0]} : 7'h00;
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         acc_q <= 7'h00;
      end else begin
         acc_q <= acc_d;
      end
   end
   assign vcoEn = enable && sum[6];
endmodule : cpmc_pll

// [cpmc_rtc_model.sv]
`timescale 1ns/1ps
module cpmc_rtc_model (
   output logic rtcWake,
   output logic rtcAccessReq,
   input wire logic ref_clk
);
   initial begin
      rtcWake = 1'b0;
      rtcAccessReq = 1'b0;
   end
   // Wake spans two edges so a slow sampler still sees it
   task automatic wake();
      @(posedge ref_clk);
      rtcWake <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rtcWake <= 1'b0;
   endtask : wake
   task automatic access(input logic on);
      @(posedge ref_clk);
      rtcAccessReq <= on;
   endtask : access
endmodule : cpmc_rtc_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   import cpmc_pkg::*;
   logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, se;
   logic rtcWake, rtcAccessReq, rtcAccessGrant, coreClkEn, sysClkEn;
   logic corePowerOn, bootStart, extWake;
   logic [11:0] paddr, coreVoltageMv;
   logic [31:0] pwdata, prdata, rv;
   int errors, num_checks, mode, msel, ssel, csel, a, b, bs, v;
   clock_power_mode_control i_clock_power_mode_control (
      .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rtcWake(rtcWake),
      .extWake(extWake), .rtcAccessReq(rtcAccessReq),
      .rtcAccessGrant(rtcAccessGrant), .coreClkEn(coreClkEn),
      .sysClkEn(sysClkEn), .corePowerOn(corePowerOn),
      .bootStart(bootStart), .coreVoltageMv(coreVoltageMv));
   cpmc_rtc_model u_rtc (.rtcWake(rtcWake), .rtcAccessReq(rtcAccessReq),
      .ref_clk(ref_clk));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] s, input int t);
      num_checks++;
      if ($isunknown(s)
          || ((t == 0) ? (e !== s) : (s + t < e || s > e + t))) begin
         errors++;
         $display("wrong value %s exp %0d got %0d", n, e, s);
      end
   endtask : chk
   // Answer is taken at the edge that sees pready high
   task automatic xfer(input logic w, input logic [11:0] ad,
      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rv = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic chk_mode(input string n);
      xfer(1'b0, CPMC_STAT_OFF, 32'h0);
      chk(n, mode, rv[2:0], 0);
   endtask : chk_mode
   task automatic cnt(input int n);
      a = 0;
      b = 0;
      bs = 0;
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         a += int'(coreClkEn === 1'b1);
         b += int'(sysClkEn === 1'b1);
         bs += int'(bootStart === 1'b1);
      end
   endtask : cnt
   task automatic rst();
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      mode = 0;
      msel = 10;
   endtask : rst
   task automatic ext();
      @(posedge ref_clk);
      extWake <= 1'b1;
      @(posedge ref_clk);
      extWake <= 1'b0;
   endtask : ext
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (60000) @(posedge ref_clk);
      errors++;
      print_verdict();
   end
   initial begin
      {resetn, psel, penable, pwrite, extWake} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      void'($urandom(73036));
      rst();
      chk_mode("mode");
      xfer(1'b0, CPMC_PLL_CONTROL_REG_OFF, 32'h0);
      chk("msel", msel, rv[5:0], 0);
      chk("volt", 1200, coreVoltageMv, 0);
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         msel = (i == 0) ? 63 : (i == 1) ? 1 : $urandom_range(63, 2);
         ssel = $urandom_range(15, 1);
         csel = i % 4;
         xfer(1'b1, CPMC_PLL_CONTROL_REG_OFF, msel);
         xfer(1'b1, CPMC_DIV_OFF, csel * 16 + ssel);
         repeat (1000) @(posedge ref_clk);
         cnt(1280);
         chk("core", 20 * msel >> csel, a, 2);
         chk("sys", 20 * msel / ssel, b, 2);
      end
      xfer(1'b1, CPMC_DIV_OFF, 32'h10);
      xfer(1'b0, CPMC_DIV_OFF, 32'h0);
      chk("ssel", ssel, rv[3:0], 0);
      cnt(1280);
      chk("sys", 20 * msel / ssel, b, 2);
      $display("divider test done");
      xfer(1'b1, CPMC_PLL_CONTROL_REG_OFF, 32'h100 | msel);
      mode = 1;
      chk_mode("active");
      cnt(100);
      chk("core", 100, a, 0);
      chk("sys", 100, b, 0);
      xfer(1'b1, CPMC_CMD_OFF, 32'h1);
      u_rtc.wake();
      chk_mode("wake");
      xfer(1'b1, CPMC_PLL_CONTROL_REG_OFF, msel);
      xfer(1'b1, CPMC_CMD_OFF, 32'h1);
      ext();
      mode = 0;
      chk_mode("wake");
      $display("sleep test done");
      u_rtc.access(1'b1);
      xfer(1'b1, CPMC_CMD_OFF, 32'h2);
      mode = 3;
      chk_mode("deep");
      cnt(100);
      chk("core", 0, a, 0);
      chk("sys", 0, b, 0);
      chk("grant", 0, rtcAccessGrant, 0);
      ext();
      chk_mode("ext");
      xfer(1'b1, CPMC_CMD_OFF, 32'h1);
      chk_mode("cmd");
      u_rtc.wake();
      mode = 1;
      chk_mode("rtc");
      chk("grant", 1, rtcAccessGrant, 0);
      xfer(1'b1, CPMC_CMD_OFF, 32'h2);
      mode = 3;
      chk_mode("deep2");
      rst();
      chk_mode("reset");
      xfer(1'b0, CPMC_PLL_CONTROL_REG_OFF, 32'h0);
      chk("bypass", 0, rv[8], 0);
      $display("deep test done");
      v = $urandom_range(15, 0);
      xfer(1'b1, CPMC_VR_OFF, v);
      @(posedge ref_clk);
      #1;
      chk("volt", 850 + 50 * v, coreVoltageMv, 0);
      xfer(1'b1, CPMC_VR_OFF, 32'h100 | v);
      #1;
      chk("power", 0, corePowerOn, 0);
      mode = 4;
      chk_mode("hib");
      fork
         u_rtc.wake();
         cnt(10);
      join
      chk("boot", 1, bs, 0);
      mode = 5;
      chk_mode("booting");
      repeat (20) @(posedge ref_clk);
      mode = 0;
      chk_mode("boot");
      chk("power", 1, corePowerOn, 0);
      u_rtc.access(1'b0);
      xfer(1'b0, 12'h020, 32'h0);
      chk("grant", 0, rtcAccessGrant, 0);
      chk("err", 1, se, 0);
      chk("rd", 0, rv, 0);
      $display("power test done");
      print_verdict();
   end
endmodule : tb_top
bind clock_power_mode_control cpmc_asserts u_chk (.ref_clk(ref_clk),
   .resetn(resetn), .psel(psel), .penable(penable), .pslverr(pslverr),
   .rtcAccessReq(rtcAccessReq), .rtcAccessGrant(rtcAccessGrant),
   .coreClkEn(coreClkEn), .sysClkEn(sysClkEn), .corePowerOn(corePowerOn),
   .bootStart(bootStart), .coreVoltageMv(coreVoltageMv));
